// >>> rtl/mode_sysctl.sv
// Purpose: system control register and per-mode bus and port roles.
// Assumes: single byte register port, read data one cycle after strobe.
// Notes: flash window only decodes; flash registers live elsewhere.
`timescale 1ns/100ps
module mode_sysctl
  import mode_ctrl_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic mode_pin_2_i,
  input wire logic mode_pin_1_i,
  input wire logic mode_pin_0_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_addr_in_ram_i,
  input wire logic all_areas_8bit_i,
  input wire logic any_area_16bit_i,
  input wire logic port_abc_addr_sel_i,
  input wire logic software_write_enable_i,
  output logic flash_reg_sel_o,
  output logic ram_sel_o,
  output logic ext_sel_o,
  output logic rom_enable_o,
  output logic ext_space_o,
  output logic bus_16bit_o,
  output logic port_abc_addr_o,
  output logic port_de_data_o,
  output logic port_fg_ctrl_o,
  output logic flash_prog_mode_o,
  output logic user_prog_mode_o,
  output logic [2:0] mode_o,
  output logic mode_valid_o
);
  op_mode_t mode;
  logic valid;
  logic [7:0] ctl_q;
  logic [7:0] ctl_view;
  logic [7:0] rdata_q;
  logic fixed_ext;
  logic ext_en;
  logic wr_ctl;
  logic bus16_q;

  // Decodes shared by the register port and the role logic.
  function automatic logic hits_sysctl(input logic [23:0] a);
    return a == SYSCTL_ADDR;
  endfunction

  function automatic logic rom_off(input op_mode_t m);
    return (m == MODE_1) || (m == MODE_2);
  endfunction

  mode_latch u_latch (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pins_i({mode_pin_2_i, mode_pin_1_i, mode_pin_0_i}),
    .mode_o(mode),
    .valid_o(valid)
  );

  // ----------------------------------------------------------------
  // System control register
  // ----------------------------------------------------------------
  assign fixed_ext = (mode == MODE_1) || (mode == MODE_2) ||
                     (mode == MODE_4); // RL6
  assign wr_ctl = wr_i && hits_sysctl(addr_i); // RL22

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_q <= SYSCTL_RESET; // RL1 RL2 RL7 RL9
    end else if (wr_ctl) begin
      ctl_q <= wdata_i & SYSCTL_WMASK; // RL5 RL1
    end
  end

  assign ext_en = fixed_ext | ctl_q[EXT_BUS_BIT]; // RL6 RL7

  always_comb begin
    ctl_view = ctl_q;
    ctl_view[RSVD_ZERO_BIT] = 1'b0; // RL5
    ctl_view[EXT_BUS_BIT] = ext_en; // RL6
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i && hits_sysctl(addr_i)) begin
      rdata_q <= ctl_view; // RL22
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Deselecting only blocks the window; flash register contents stay.
  assign flash_reg_sel_o = HAS_FLASH && ctl_q[FLASH_GATE_BIT] &&
                           (addr_i >= FLASH_WIN_LO) &&
                           (addr_i <= FLASH_WIN_HI); // RL2 RL3
  assign ram_sel_o = cpu_addr_in_ram_i &&
                     (!ext_en || ctl_q[RAM_EN_BIT]); // RL10
  assign ext_sel_o = cpu_addr_in_ram_i && ext_en &&
                     !ctl_q[RAM_EN_BIT]; // RL10

  // ----------------------------------------------------------------
  // Mode-dependent roles
  // ----------------------------------------------------------------
  assign rom_enable_o = valid && !rom_off(mode); // RL12 RL15
  assign ext_space_o = valid && ext_en; // RL17

  // Bus width follows the bus controller area settings in modes 1, 2 and 4, and the external bus enable in modes 3, 5 and 7.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus16_q <= 1'b0;
    end else if (!valid) begin
      bus16_q <= 1'b0;
    end else if (mode == MODE_1) begin
      bus16_q <= !all_areas_8bit_i; // RL13
    end else if (fixed_ext) begin
      bus16_q <= any_area_16bit_i; // RL14
    end else begin
      bus16_q <= ext_en; // RL18
    end
  end
  assign bus_16bit_o = bus16_q;

  assign port_abc_addr_o = valid && ext_en &&
      (rom_off(mode) || port_abc_addr_sel_i); // RL12 RL15 RL18
  assign port_de_data_o = valid && ext_en; // RL12 RL17
  assign port_fg_ctrl_o = valid && ext_en; // RL12 RL18
  assign flash_prog_mode_o = HAS_FLASH && valid &&
      ((mode == MODE_3) || (mode == MODE_5)); // RL16
  assign user_prog_mode_o = HAS_FLASH && valid &&
      ((mode == MODE_4) || (mode == MODE_7)) &&
      software_write_enable_i; // RL19
  assign mode_o = mode;
  assign mode_valid_o = valid;
endmodule

// >>> rtl/mode_ctrl_pkg.sv
// What this block does
// (RL1) Bits 7,6 reset to one, bits 5,4 to zero; all writable.
// (RL2) Flash gate bit 3 resets zero; one selects flash registers at window.
// (RL3) Gate zero deselects flash registers but keeps their contents.
// (RL4) Parts without flash: software writes only zero to flash gate.
// (RL5) Bit 2 always reads zero and ignores writes.
// (RL6) Modes 1, 2, 4: external bus enable reads one, ignores writes.
// (RL7) Modes 3, 7: external bus enable resets zero, freely writable.
// (RL8) Software clears external bus enable only outside external cycles.
// (RL9) RAM enable set at reset release; written zero or one.
// (RL10) RAM range: external if bus enabled and RAM off, else RAM.
// (RL11) Software keeps RAM enabled on flash parts, avoids reserved areas.
// (RL12) Modes 1, 2: ROM off, ports A-C address, D-E data, F-G control.
// (RL13) Mode 1: 16-bit bus after reset; 8-bit only if all areas 8-bit.
// (RL14) Modes 2, 4: 8-bit after reset; 16-bit, port E data, if any 16. Code: port_de_data_o is set in both modes regardless of area width.
// (RL15) Mode 4: ROM on, ports A-C input after reset, switchable to address.
// (RL16) Modes 3, 5 act as mode 7 plus flash programming allowed.
// (RL17) Mode 7 single-chip; setting bus enable gives expanded operation.
// (RL18) Mode 7 expanded: areas 16-bit, ports as mode 4.
// (RL19) Flash parts, modes 4 and 7: write enable bit enters user program.
// (RL20) Mode pins 001..111 select modes 1,2,3,4,5,7.
// (RL21) Board holds mode pins constant while running.
// (RL22) System control is one byte, read whole.
// (RL23) Mode pins sampled at reset release, held until next reset.
//
// Purpose: constants for the operating mode and system control block.
// Assumes: byte-wide register port, 24-bit CPU address.
// Notes: none.
package mode_ctrl_pkg;
  localparam logic [23:0] SYSCTL_ADDR = 24'hFFFF3D;
  localparam logic [23:0] FLASH_WIN_LO = 24'hFFFFC8;
  localparam logic [23:0] FLASH_WIN_HI = 24'hFFFFCB;
  localparam logic [7:0] SYSCTL_RESET = 8'hC1;
  localparam int FLASH_GATE_BIT = 3;
  localparam int RSVD_ZERO_BIT = 2;
  localparam int EXT_BUS_BIT = 1;
  localparam int RAM_EN_BIT = 0;
  localparam logic [7:0] SYSCTL_WMASK = 8'hFB;
  localparam logic [1:0] MODE_TAKE_CNT = 2'h2;
  localparam logic [1:0] MODE_VALID_CNT = 2'h3;
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } op_mode_t;
endpackage

// >>> rtl/mode_latch.sv
// Purpose: synchronise mode pins and latch them once after reset.
// Assumes: pins are static while running.
// Notes: mode_valid_o rises a few cycles after release.
`timescale 1ns/100ps
module mode_latch
  import mode_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [2:0] pins_i,
  output op_mode_t mode_o,
  output logic valid_o
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [1:0] cnt_q;
  op_mode_t mode_q;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
    end
  end
  // Latch exactly once after the synchroniser has filled.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 2'h0;
      mode_q <= MODE_NONE;
    end else if (cnt_q != MODE_VALID_CNT) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == MODE_TAKE_CNT) begin
        mode_q <= op_mode_t'(s2_q); // RL23 RL20
      end
    end
  end
  assign mode_o = mode_q;
  assign valid_o = (cnt_q == MODE_VALID_CNT);
endmodule

// >>> tb/mode_pins_model.sv
// Purpose: board strapping that drives the three mode pins.
// Assumes: the selection moves only while the device is in reset.
// Notes: plain levels, no pull.
`timescale 1ns/100ps
module mode_pins_model (
  input wire logic [2:0] mode_sel_i,
  output logic pin_2_o,
  output logic pin_1_o,
  output logic pin_0_o
);
  assign {pin_2_o, pin_1_o, pin_0_o} = mode_sel_i;
endmodule

// >>> tb/mode_sysctl_monitor.sv
// Purpose: port assertions for the system control block.
// Assumes: mode pins static between resets.
// Notes: bound from the bench top.
`timescale 1ns/100ps
module mode_sysctl_monitor
  import mode_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [23:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic flash_reg_sel_o,
  input wire logic ram_sel_o,
  input wire logic ext_sel_o,
  input wire logic cpu_addr_in_ram_i,
  input wire logic rom_enable_o,
  input wire logic port_abc_addr_o,
  input wire logic ext_space_o,
  input wire logic bus_16bit_o,
  input wire logic all_areas_8bit_i,
  input wire logic any_area_16bit_i,
  input wire logic [2:0] mode_o,
  input wire logic mode_valid_o
);
  logic fixed;
  logic exp16;
  assign fixed = mode_valid_o && mode_o inside {3'h1, 3'h2, 3'h4};
  // Bus width expected one edge later from mode, area settings and ext_space_o.
  assign exp16 = (mode_o == 3'h1) ? !all_areas_8bit_i :
                 (fixed ? any_area_16bit_i : ext_space_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_rsvd_zero: assert property (!rdata_o[2]) else $error("bit2");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("rdata idle");
  a_bus_fixed: assert property (rd_i && addr_i == SYSCTL_ADDR && fixed
    |=> rdata_o[1]) else $error("bus bit");
  a_mode_held: assert property ($past(mode_valid_o) |-> $stable(mode_o))
    else $error("mode moved");
  a_flash_win: assert property (flash_reg_sel_o
    |-> addr_i >= FLASH_WIN_LO && addr_i <= FLASH_WIN_HI) else $error("win");
  a_ram_route: assert property (mode_valid_o && cpu_addr_in_ram_i
    |-> ram_sel_o != ext_sel_o) else $error("ram route");
  a_rom_off: assert property (mode_valid_o && mode_o inside {3'd1, 3'd2}
    |-> !rom_enable_o && port_abc_addr_o) else $error("rom off");
  a_rom_on: assert property (mode_valid_o && mode_o > 3'd2
    && mode_o != 3'd6 |-> rom_enable_o) else $error("rom on");
  a_bus_width: assert property (mode_valid_o
    |=> bus_16bit_o == $past(exp16)) else $error("bus width");
  c_flash: cover property (flash_reg_sel_o);
  c_ext: cover property (ext_sel_o);
  c_fixed_rd: cover property (fixed && rd_i);
endmodule

// >>> tb/tb_operating_mode_system_control.sv
// Purpose: self-checking bench for the system control block.
// Assumes: mode pins move only while reset is held.
// Notes: modes 1 to 5 and 7 are each visited once.
`timescale 1ns/100ps
module tb_operating_mode_system_control;
  import mode_ctrl_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, rd_q = 0;
  logic mode_pin_2_i, mode_pin_1_i, mode_pin_0_i, flash_reg_sel_o;
  logic [23:0] addr_i = '0;
  logic [7:0] wdata_i = '0, rdata_o, fx, rv;
  logic [2:0] mode_sel = 3'h7, mode_o;
  logic [4:0] side_i = '0;
  logic [31:0] seed = 32'h771F1818;
  logic [7:0] exp_q[$];
  localparam bit FLASH_PART = 1'b1;
  wire logic [8:0] lv;
  logic [8:0] le;
  logic [2:0] cur_m;
  logic ext_x;
  int miscompares = 0, checked = 0;
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  mode_pins_model pins (.mode_sel_i(mode_sel), .pin_2_o(mode_pin_2_i),
    .pin_1_o(mode_pin_1_i), .pin_0_o(mode_pin_0_i));
  mode_sysctl #(.HAS_FLASH(FLASH_PART)) dut (.sys_clk_i, .reset_i,
    .mode_pin_2_i, .mode_pin_1_i,
    .mode_pin_0_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cpu_addr_in_ram_i(side_i[4]), .all_areas_8bit_i(side_i[3]),
    .any_area_16bit_i(side_i[2]), .port_abc_addr_sel_i(side_i[1]),
    .software_write_enable_i(side_i[0]), .flash_reg_sel_o,
    .ram_sel_o(lv[8]), .ext_sel_o(lv[7]), .rom_enable_o(lv[6]),
    .ext_space_o(lv[5]), .bus_16bit_o(), .port_abc_addr_o(lv[4]),
    .port_de_data_o(lv[3]), .port_fg_ctrl_o(lv[2]),
    .flash_prog_mode_o(lv[1]), .user_prog_mode_o(lv[0]), .mode_o,
    .mode_valid_o());
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_lvl(input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value levels exp %h got %h", e, g);
    end
  endtask
  task test_done();
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One strobe per cycle; a read notes its expected byte.
  task acc(input logic w, input logic [23:0] a, input logic [7:0] d, e);
    @(posedge sys_clk_i);
    side_i <= 5'(xs() >> 27);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w) exp_q.push_back(e);
  endtask
  task idle();
    @(posedge sys_clk_i);
    wr_i <= 0;
    rd_i <= 0;
  endtask
  task fsel(input logic [23:0] a, input logic e);
    acc(0, a, 0, 0);
    @(negedge sys_clk_i);
    chk("fsel", {7'h0, e}, {7'h0, flash_reg_sel_o});
    // RAM stays enabled, so RAM-range accesses never go outside.
    le = {side_i[4], 1'b0, cur_m > 3'h2, ext_x,
      ext_x && (cur_m < 3'h3 || side_i[1]), ext_x, ext_x,
      cur_m == 3'h3 || cur_m == 3'h5,
      (cur_m == 3'h4 || cur_m == 3'h7) && side_i[0]};
    chk_lvl(le, lv);
  endtask
  task run(input logic [2:0] m);
    idle();
    reset_i <= 1;
    mode_sel <= m;
    cur_m = m;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("mode", {5'h0, m}, {5'h0, mode_o});
    fx = (m == 3'd1 || m == 3'd2 || m == 3'd4) ? 8'h02 : 8'h00;
    acc(0, SYSCTL_ADDR, 0, SYSCTL_RESET | fx);
    // Bits 7 to 4 and RAM enable keep their reset values; the gate
    // is only set on a flash part.
    rv = 8'(xs()) & {4'h0, FLASH_PART, 3'h6} | SYSCTL_RESET;
    acc(1, SYSCTL_ADDR, rv, 0);
    acc(0, SYSCTL_ADDR, 0, rv & SYSCTL_WMASK | fx);
    acc(1, SYSCTL_ADDR, SYSCTL_RESET, 0);
    acc(0, SYSCTL_ADDR, 0, SYSCTL_RESET | fx);
    acc(1, SYSCTL_ADDR, {4'hC, FLASH_PART, 3'h3}, 0);
    ext_x = 1'b1;
    fsel(FLASH_WIN_LO, FLASH_PART);
    fsel(FLASH_WIN_HI, FLASH_PART);
    fsel(FLASH_WIN_HI + 24'h1, 0);
    acc(1, SYSCTL_ADDR, SYSCTL_RESET, 0);
    ext_x = fx[1];
    fsel(FLASH_WIN_LO, 0);
    acc(0, SYSCTL_ADDR, 0, SYSCTL_RESET | fx);
    idle();
  endtask
  always @(posedge sys_clk_i) rd_q <= rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_q) chk("rdata", exp_q.pop_front(), rdata_o);
  end
  initial begin
    for (int i = 1; i < 8; i++) if (i != 6) run(3'(i));
    idle();
    if (exp_q.size() != 0) miscompares++;
    test_done();
  end
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    miscompares++;
    test_done();
  end
endmodule
bind mode_sysctl mode_sysctl_monitor mon (.sys_clk_i, .reset_i, .addr_i,
  .rd_i, .rdata_o, .flash_reg_sel_o, .ram_sel_o, .ext_sel_o,
  .cpu_addr_in_ram_i, .rom_enable_o, .port_abc_addr_o, .ext_space_o,
  .bus_16bit_o, .all_areas_8bit_i, .any_area_16bit_i, .mode_o,
  .mode_valid_o);
